// file: btc_pkg.sv
package btc_pkg;
  // Register byte offsets (32-bit aligned words)
  localparam logic [5:0] BTC_OFS_CTRL = 6'h00;
  localparam logic [5:0] BTC_OFS_CMD = 6'h04;
  localparam logic [5:0] BTC_OFS_STATUS = 6'h08;
  localparam logic [5:0] BTC_OFS_CNT = 6'h0C;
  localparam logic [5:0] BTC_OFS_PER = 6'h10;
  localparam logic [5:0] BTC_OFS_PERIOD_BUFFER = 6'h14;
  localparam logic [5:0] BTC_OFS_CMP0 = 6'h18;
  localparam logic [5:0] BTC_OFS_CMPBUF0 = 6'h24;
  localparam logic [5:0] BTC_OFS_STEP = 6'h04;
  // Control field positions
  localparam int BTC_CTRL_ENABLE = 0;
  localparam int BTC_CTRL_PSC_LSB = 1;
  localparam int BTC_CTRL_EVCNT = 4;
  localparam int BTC_CTRL_DIR = 5;
  localparam int BTC_CTRL_LOCK = 6;
  localparam int BTC_CTRL_WGM_LSB = 8;
  localparam int BTC_CTRL_OE_LSB = 12;
  // Command bits
  localparam int BTC_CMD_UPDATE = 0;
  localparam int BTC_CMD_RESTART = 1;
  // Reset values, count limits and unmapped read value
  localparam logic [15:0] BTC_CNT_RST = 16'h0000;
  localparam logic [15:0] BTC_PER_RST = 16'hFFFF;
  localparam logic [15:0] BTC_CMP_RST = 16'h0000;
  localparam logic [15:0] BTC_FLOOR = 16'h0000;
  localparam logic [15:0] BTC_MAX = 16'hFFFF;
  localparam logic [31:0] BTC_RD_UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {
    BTC_WG_NORMAL,
    BTC_WG_FRQ,
    BTC_WG_SS,
    BTC_WG_DS
  } btc_wg_e;
endpackage

// file: btc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Prescaler: tick every selected power of two
// ****************************************
module btc_prescaler #(
  parameter int DIV_BITS = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [2:0] sel,
  // Tick
  output logic tick
);
  logic [DIV_BITS-1:0] div_reg;
  logic [DIV_BITS-1:0] mask;

  always_comb begin
    mask = '0;
    for (int i = 0; i < DIV_BITS; i++) begin
      // Divide by 1,2,4,8,16 then 64,256,1024
      if (sel <= 3'd4) begin
        mask[i] = i < int'(sel);
      end else begin
        mask[i] = i < 2 * int'(sel) - 4;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (!run) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DIV_BITS'(1);
    end
  end

  assign tick = run && ((div_reg & mask) == mask);
endmodule
`default_nettype wire

// file: btc_timer.sv
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module btc_timer
  import btc_pkg::*;
#(
  parameter int NCH = 3,
  parameter int DIV_BITS = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event input from pin
  input wire logic event_in,
  // Waveform pins
  output logic [NCH-1:0] waveform_output,
  output logic [NCH-1:0] waveform_override,
  // Match, ceiling and floor events
  output logic [NCH-1:0] match_event,
  output logic ceiling_event,
  output logic floor_event
);
  // ****************************************
  // Registers
  // ****************************************
  logic enable_reg, event_count_enable, count_dir_reg, update_lock;
  logic [2:0] prescale_select;
  btc_wg_e waveform_mode_select;
  logic [NCH-1:0] compare_output_enable;
  logic [15:0] cnt_reg, per_reg, period_buffer;
  logic period_buffer_valid;
  logic [15:0] compare_value [NCH];
  logic [15:0] compare_buffer [NCH];
  logic [NCH-1:0] compare_buffer_valid, match_flag_reg;
  logic [NCH-1:0] wave_reg;
  logic ovf_flag_reg;
  logic [1:0] ev_sync_reg;
  logic ev_prev_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  logic req, wr_hit;
  logic [31:0] wmask, wd;
  assign req = (avs_read || avs_write) && !ack_reg;
  // Writes land on the edge that completes the transfer
  assign wr_hit = avs_write && ack_reg;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  logic [31:0] ctrl_word;
  assign ctrl_word = {{(20-NCH){1'b0}}, compare_output_enable, 2'b00,
                      2'(waveform_mode_select), 1'b0, update_lock,
                      count_dir_reg, event_count_enable, prescale_select,
                      enable_reg};
  assign wd = (ctrl_word & ~wmask) | (avs_writedata & wmask);
  logic wr_ctrl, wr_cmd, wr_cnt, wr_per, wr_period_buffer;
  logic [NCH-1:0] wr_cmp, wr_cmpbuf;
  logic [15:0] wd16;
  assign wd16 = avs_writedata[15:0];
  assign wr_ctrl = wr_hit && avs_address == BTC_OFS_CTRL;
  assign wr_cmd = wr_hit && avs_address == BTC_OFS_CMD;
  assign wr_cnt = wr_hit && avs_address == BTC_OFS_CNT;
  assign wr_per = wr_hit && avs_address == BTC_OFS_PER;
  assign wr_period_buffer = wr_hit && avs_address == BTC_OFS_PERIOD_BUFFER;

  // ****************************************
  // Tick generation
  // ****************************************
  logic pre_tick, ev_tick, tick;
  btc_prescaler #(.DIV_BITS(DIV_BITS)) u_psc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(enable_reg && !event_count_enable),
    .sel(prescale_select),
    .tick(pre_tick)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_sync_reg <= 2'b00;
      ev_prev_reg <= 1'b0;
    end else begin
      ev_sync_reg <= {ev_sync_reg[0], event_in};
      ev_prev_reg <= ev_sync_reg[1];
    end
  end

  assign ev_tick = ev_sync_reg[1] && !ev_prev_reg;
  assign tick = enable_reg && (event_count_enable ? ev_tick : pre_tick);

  // ****************************************
  // Count conditions
  // ****************************************
  logic frq_mode, restart_cmd, update_cmd;
  logic [15:0] ceiling;
  logic at_floor, at_ceiling, at_max, xfer_point, do_xfer;
  assign frq_mode = waveform_mode_select == BTC_WG_FRQ;
  assign restart_cmd = wr_cmd && avs_writedata[BTC_CMD_RESTART];
  assign update_cmd = wr_cmd && avs_writedata[BTC_CMD_UPDATE];
  assign ceiling = frq_mode ? compare_value[0] : per_reg;
  assign at_floor = cnt_reg == BTC_FLOOR;
  assign at_max = cnt_reg == BTC_MAX;
  assign at_ceiling = cnt_reg == ceiling;
  assign xfer_point = tick && (waveform_mode_select == BTC_WG_DS ?
                      at_floor : (count_dir_reg ? at_floor : at_ceiling));
  assign do_xfer = (xfer_point && !update_lock) || update_cmd;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      prescale_select <= 3'd0;
      event_count_enable <= 1'b0;
      update_lock <= 1'b0;
      waveform_mode_select <= BTC_WG_NORMAL;
      compare_output_enable <= '0;
    end else if (wr_ctrl) begin
      enable_reg <= wd[BTC_CTRL_ENABLE];
      prescale_select <= wd[BTC_CTRL_PSC_LSB +: 3];
      event_count_enable <= wd[BTC_CTRL_EVCNT];
      update_lock <= wd[BTC_CTRL_LOCK];
      waveform_mode_select <= btc_wg_e'(wd[BTC_CTRL_WGM_LSB +: 2]);
      compare_output_enable <= wd[BTC_CTRL_OE_LSB +: NCH];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_dir_reg <= 1'b0;
    end else if (restart_cmd) begin
      count_dir_reg <= 1'b0;
    end else if (wr_ctrl) begin
      count_dir_reg <= wd[BTC_CTRL_DIR];
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= BTC_CNT_RST;
    end else if (wr_cnt) begin
      cnt_reg <= wd16;
    end else if (restart_cmd) begin
      cnt_reg <= BTC_CNT_RST;
    end else if (tick) begin
      if (count_dir_reg) begin
        cnt_reg <= at_floor ? ceiling : cnt_reg - 16'h0001;
      end else begin
        cnt_reg <= (at_ceiling || at_max) ? BTC_FLOOR : cnt_reg + 16'h0001;
      end
    end
  end

  // ****************************************
  // Period and buffer
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_reg <= BTC_PER_RST;
    end else if (wr_per) begin
      per_reg <= wd16;
    end else if (do_xfer && period_buffer_valid) begin
      per_reg <= period_buffer;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_buffer <= BTC_PER_RST;
    end else if (wr_period_buffer) begin
      period_buffer <= wd16;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_buffer_valid <= 1'b0;
    end else if (wr_period_buffer) begin
      period_buffer_valid <= 1'b1;
    end else if (do_xfer) begin
      period_buffer_valid <= 1'b0;
    end
  end

  // ****************************************
  // Compare channels
  // ****************************************
  logic [NCH-1:0] match;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign wr_cmp[g] = wr_hit &&
        avs_address == 6'(BTC_OFS_CMP0 + g * BTC_OFS_STEP);
      assign wr_cmpbuf[g] = wr_hit &&
        avs_address == 6'(BTC_OFS_CMPBUF0 + g * BTC_OFS_STEP);
      assign match[g] = cnt_reg == compare_value[g];

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          compare_value[g] <= BTC_CMP_RST;
        end else if (wr_cmp[g]) begin
          compare_value[g] <= wd16;
        end else if (do_xfer && compare_buffer_valid[g]) begin
          compare_value[g] <= compare_buffer[g];
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          compare_buffer[g] <= BTC_CMP_RST;
        end else if (wr_cmpbuf[g]) begin
          compare_buffer[g] <= wd16;
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          compare_buffer_valid[g] <= 1'b0;
        end else if (wr_cmpbuf[g]) begin
          compare_buffer_valid[g] <= 1'b1;
        end else if (do_xfer) begin
          compare_buffer_valid[g] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          match_flag_reg[g] <= 1'b0;
        end else if (tick && match[g]) begin
          match_flag_reg[g] <= 1'b1;
        end else if (wr_hit && avs_address == BTC_OFS_STATUS &&
                     avs_writedata[g]) begin
          match_flag_reg[g] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          wave_reg[g] <= 1'b0;
        end else if (restart_cmd) begin
          wave_reg[g] <= 1'b0;
        end else if (tick && match[g] && frq_mode) begin
          wave_reg[g] <= ~wave_reg[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Outputs and events
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waveform_override <= '0;
      waveform_output <= '0;
    end else begin
      waveform_override <= (waveform_mode_select != BTC_WG_NORMAL) ?
                           compare_output_enable : '0;
      waveform_output <= wave_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_event <= '0;
      ceiling_event <= 1'b0;
      floor_event <= 1'b0;
    end else begin
      match_event <= tick ? match : '0;
      ceiling_event <= tick && !count_dir_reg && (at_ceiling || at_max);
      floor_event <= tick && count_dir_reg && at_floor;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_reg <= 1'b0;
    end else if (tick && (count_dir_reg ? at_floor : at_ceiling)) begin
      ovf_flag_reg <= 1'b1;
    end else if (wr_hit && avs_address == BTC_OFS_STATUS &&
                 avs_writedata[8]) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  // ****************************************
  // Read mux and handshake
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = BTC_RD_UNMAPPED;
    if (avs_address == BTC_OFS_CTRL) begin
      rd_mux = ctrl_word;
    end else if (avs_address == BTC_OFS_STATUS) begin
      rd_mux[0 +: NCH] = match_flag_reg;
      rd_mux[8] = ovf_flag_reg;
      rd_mux[9] = period_buffer_valid;
      rd_mux[10 +: NCH] = compare_buffer_valid;
    end else if (avs_address == BTC_OFS_CNT) begin
      rd_mux = {16'h0000, cnt_reg};
    end else if (avs_address == BTC_OFS_PER) begin
      rd_mux = {16'h0000, per_reg};
    end else if (avs_address == BTC_OFS_PERIOD_BUFFER) begin
      rd_mux = {16'h0000, period_buffer};
    end
    for (int i = 0; i < NCH; i++) begin
      if (avs_address == 6'(BTC_OFS_CMP0 + i * BTC_OFS_STEP)) begin
        rd_mux = {16'h0000, compare_value[i]};
      end
      if (avs_address == 6'(BTC_OFS_CMPBUF0 + i * BTC_OFS_STEP)) begin
        rd_mux = {16'h0000, compare_buffer[i]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      rdata_reg <= '0;
    end else begin
      ack_reg <= req;
      avs_waitrequest <= !req;
      if (req && avs_read) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign avs_readdata = rdata_reg;
endmodule
`default_nettype wire

// file: btc_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the timer core
// ****************************************
module btc_timer_properties
  import btc_pkg::*;
#(
  parameter int NCH = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Timer outputs
  input wire logic [NCH-1:0] waveform_output,
  input wire logic [NCH-1:0] waveform_override,
  input wire logic [NCH-1:0] match_event,
  input wire logic ceiling_event,
  input wire logic floor_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic ctl_wr;
  logic cmd_wr;
  assign ctl_wr = avs_write && avs_address == BTC_OFS_CTRL;
  assign cmd_wr = avs_write && avs_address == BTC_OFS_CMD;

  AST_ACK_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  AST_ACK_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_NO_ACK_IDLE: assert property (!avs_read && !avs_write
    |=> avs_waitrequest) else $error("answer without request");
  AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest
    && avs_address > 6'h2C |-> avs_readdata == BTC_RD_UNMAPPED)
    else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (avs_read && !avs_waitrequest
    && avs_address == BTC_OFS_CNT |-> avs_readdata[31:16] == 16'h0000)
    else $error("counter upper half not zero");
  AST_OVERRIDE_CAUSE: assert property (
    !$stable(waveform_override) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("override changed without control write");
  AST_WAVE_CAUSE: assert property (
    |((waveform_output ^ $past(waveform_output)) & ~$past(match_event))
    |-> $past(cmd_wr) || $past(cmd_wr, 2))
    else $error("waveform changed without match");
  AST_FLOOR_PULSE: assert property (floor_event |=> !floor_event)
    else $error("floor event longer than one cycle");
  AST_CEIL_FLOOR_APART: assert property (
    !(ceiling_event && floor_event))
    else $error("ceiling and floor together");
endmodule

bind btc_timer btc_timer_properties #(.NCH(NCH)) u_props (
  .core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .waveform_output,
  .waveform_override, .match_event, .ceiling_event, .floor_event);
`default_nettype wire

// file: btc_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module btc_timer_bench
  import btc_pkg::*;
;
  localparam logic [15:0] en_b = 16'h0001;
  localparam logic [15:0] evc_b = 16'h0001 << BTC_CTRL_EVCNT;
  localparam logic [15:0] dn_b = 16'h0001 << BTC_CTRL_DIR;
  localparam logic [15:0] lk_b = 16'h0001 << BTC_CTRL_LOCK;
  localparam logic [15:0] frq_b = 16'h0001 << BTC_CTRL_WGM_LSB;
  localparam logic [15:0] oe_b = 16'h0003 << BTC_CTRL_OE_LSB;
  localparam logic [5:0] cmp1_a = BTC_OFS_CMP0 + BTC_OFS_STEP;
  localparam logic [5:0] cmp2_a = BTC_OFS_CMP0 + 6'h08;
  localparam logic [5:0] buf2_a = BTC_OFS_CMPBUF0 + 6'h08;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic event_in = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] wave;
  logic [2:0] ovr;
  logic [31:0] q;
  logic [31:0] q1;
  logic [2:0] mev;
  logic cev;
  logic fev;
  int n_ceil = 0;
  int n_floor = 0;
  int n_m0 = 0;
  int fails = 0;
  int checked = 0;
  int i;
  int sh[8] = '{0, 1, 2, 3, 4, 6, 8, 10};

  always #12.5 core_clk = ~core_clk;

  btc_timer #(.NCH(3), .DIV_BITS(10)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_in(event_in), .waveform_output(wave),
    .waveform_override(ovr), .match_event(mev), .ceiling_event(cev),
    .floor_event(fev));

  // Event pulse counters
  always @(posedge core_clk) begin
    if (cev) begin
      n_ceil++;
    end
    if (fev) begin
      n_floor++;
    end
    if (mev[0]) begin
      n_m0++;
    end
  end

  // ****************************************
  // Bus and event tasks
  // ****************************************
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    acc(1'b1, a, {16'h0000, d});
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] m,
                    input logic [15:0] e);
    acc(1'b0, a, 32'h0000_0000);
    `CHK(q & {16'hFFFF, m}, {16'h0000, e})
  endtask

  task automatic ev(input int k);
    repeat (k) begin
      @(posedge core_clk);
      event_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      event_in <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    summarize();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(BTC_OFS_PER, 16'hFFFF, BTC_PER_RST);
    rd(BTC_OFS_CNT, 16'hFFFF, BTC_CNT_RST);
    rd(BTC_OFS_CMP0, 16'hFFFF, BTC_CMP_RST);
    wr(6'h30, 16'h1234);
    rd(6'h30, 16'hFFFF, 16'h0000);
    wr(BTC_OFS_PER, 16'h0003);
    wr(BTC_OFS_CTRL, en_b | evc_b);
    ev(2);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0002);
    ev(2);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0000);
    rd(BTC_OFS_STATUS, 16'h0100, 16'h0100);
    `CHK(n_ceil, 1)
    wr(BTC_OFS_CTRL, en_b | evc_b | dn_b);
    ev(1);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0003);
    `CHK(n_floor, 1)
    wr(BTC_OFS_CNT, 16'h0007);
    ev(1);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0006);
    wr(BTC_OFS_CTRL, en_b | evc_b);
    wr(BTC_OFS_CNT, 16'hFFFE);
    ev(1);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'hFFFF);
    ev(1);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0000);
    wr(BTC_OFS_PER, 16'h0001);
    rd(BTC_OFS_PER, 16'hFFFF, 16'h0001);
    ev(2);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0000);
    wr(BTC_OFS_PERIOD_BUFFER, 16'h0005);
    rd(BTC_OFS_STATUS, 16'h0200, 16'h0200);
    rd(BTC_OFS_PER, 16'hFFFF, 16'h0001);
    ev(2);
    rd(BTC_OFS_PER, 16'hFFFF, 16'h0005);
    rd(BTC_OFS_STATUS, 16'h0200, 16'h0000);
    wr(BTC_OFS_CTRL, en_b | evc_b | lk_b);
    wr(BTC_OFS_CNT, 16'h0000);
    wr(BTC_OFS_PERIOD_BUFFER, 16'h0002);
    ev(7);
    rd(BTC_OFS_PER, 16'hFFFF, 16'h0005);
    rd(BTC_OFS_STATUS, 16'h0200, 16'h0200);
    wr(BTC_OFS_CTRL, en_b | evc_b);
    ev(7);
    rd(BTC_OFS_PER, 16'hFFFF, 16'h0002);
    wr(BTC_OFS_CTRL, 16'h0000);
    wr(cmp2_a, 16'h0004);
    rd(cmp2_a, 16'hFFFF, 16'h0004);
    wr(buf2_a, 16'h0007);
    rd(buf2_a, 16'hFFFF, 16'h0007);
    rd(BTC_OFS_STATUS, 16'h1000, 16'h1000);
    rd(cmp2_a, 16'hFFFF, 16'h0004);
    wr(BTC_OFS_CNT, 16'h0000);
    wr(BTC_OFS_PER, 16'h0009);
    wr(BTC_OFS_CMP0, 16'h0002);
    wr(cmp1_a, 16'h0001);
    wr(BTC_OFS_STATUS, 16'h0107);
    rd(BTC_OFS_STATUS, 16'h0003, 16'h0000);
    wr(BTC_OFS_CTRL, en_b | evc_b | frq_b | oe_b);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0000);
    `CHK(ovr, 3'h3)
    `CHK(wave, 3'h0)
    i = n_m0;
    ev(3);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0000);
    `CHK(n_m0 - i, 1)
    `CHK(wave, 3'h3)
    rd(BTC_OFS_STATUS, 16'h0003, 16'h0003);
    rd(cmp2_a, 16'hFFFF, 16'h0007);
    ev(3);
    `CHK(wave, 3'h0)
    ev(2);
    wr(BTC_OFS_CTRL, en_b | evc_b | frq_b | oe_b | dn_b);
    wr(BTC_OFS_CMD, 16'h0001 << BTC_CMD_RESTART);
    rd(BTC_OFS_CNT, 16'hFFFF, 16'h0000);
    `CHK(wave, 3'h0)
    rd(BTC_OFS_CTRL, dn_b, 16'h0000);
    wr(BTC_OFS_CTRL, lk_b);
    wr(BTC_OFS_PERIOD_BUFFER, 16'h0ABC);
    wr(BTC_OFS_CMD, 16'h0001 << BTC_CMD_UPDATE);
    rd(BTC_OFS_PER, 16'hFFFF, 16'h0ABC);
    rd(BTC_OFS_STATUS, 16'h0200, 16'h0000);
    wr(BTC_OFS_PER, 16'hFFFF);
    for (i = 0; i < 8; i++) begin
      wr(BTC_OFS_CTRL, en_b | (16'(i) << BTC_CTRL_PSC_LSB));
      acc(1'b0, BTC_OFS_CNT, 32'h0000_0000);
      q1 = q;
      repeat (2045) @(posedge core_clk);
      rd(BTC_OFS_CNT, 16'hFFFF, q1[15:0] + (16'h0800 >> sh[i]));
    end
    summarize();
  end
endmodule
`default_nettype wire
